// [pkg/fcr_regs.svh]
// Purpose: named constants for the floppy command/result sequencer
// Assumes: byte-wide host command and result transfers
// Notes: opcodes are matched on their low five bits where flags ride above
`ifndef FCR_REGS_SVH
`define FCR_REGS_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define FCR_OP_MASK 8'h1F
`define FCR_OP_SCAN_EQ 8'h11
`define FCR_OP_SCAN_LE 8'h19
`define FCR_OP_SCAN_HE 8'h1D
`define FCR_OP_RECAL 8'h07
`define FCR_OP_SENSE_INT 8'h08
`define FCR_OP_SPECIFY 8'h03
`define FCR_OP_SENSE_DRV 8'h04
`define FCR_OP_SEEK 8'h0F

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FCR_BIT_MT 7
`define FCR_BIT_MF 6
`define FCR_BIT_SK 5
`define FCR_BIT_HD 2
`define FCR_BIT_US1 1
`define FCR_BIT_US0 0
`define FCR_SRT_LSB 4
`define FCR_HLT_LSB 1
`define FCR_BIT_ND 0

// ----------------------------------------------------------------
// Byte counts, indices and fixed values
// ----------------------------------------------------------------
`define FCR_LEN_SCAN 4'h9
`define FCR_LEN_ONE 4'h1
`define FCR_LEN_TWO 4'h2
`define FCR_LEN_THREE 4'h3
`define FCR_RES_SCAN 4'h7
`define FCR_RES_NONE 4'h0
`define FCR_IDX_0 4'h0
`define FCR_IDX_1 4'h1
`define FCR_IDX_2 4'h2
`define FCR_IDX_3 4'h3
`define FCR_IDX_4 4'h4
`define FCR_IDX_5 4'h5
`define FCR_IDX_6 4'h6
`define FCR_IDX_7 4'h7
`define FCR_IDX_8 4'h8
`define FCR_ST0_INVALID 8'h80
`define FCR_SENSE_IDLE 5'h1F
`define FCR_CTRL_IDLE 3'h7

`endif

// [pkg/fcr_pkg.sv]
// Purpose: types and decode helpers for the floppy command/result sequencer
// Assumes: fcr_regs.svh holds every numeric constant
// Notes: opcodes outside this set decode as invalid
`include "fcr_regs.svh"

package fcr_pkg;

  typedef enum logic [2:0] {
    fcr_k_scan, fcr_k_recal, fcr_k_sense_int, fcr_k_specify,
    fcr_k_sense_drv, fcr_k_seek, fcr_k_invalid
  } fcr_kind_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic multi_track_flag;
    logic density_select_flag;
    logic skip_deleted_flag;
    logic head_select;
    logic unit_select_high;
    logic unit_select_low;
    logic [7:0] cylinder;
    logic [7:0] head_addr;
    logic [7:0] sector;
    logic [7:0] size_code;
    logic [7:0] end_of_track;
    logic [7:0] gap_length;
    logic [7:0] scan_test;
    logic [3:0] step_rate_time;
    logic [3:0] head_unload_time;
    logic [6:0] head_load_time;
    logic non_dma_select;
  } fcr_cmd_t;

  typedef struct packed {
    logic [7:0] st0;
    logic [7:0] st1;
    logic [7:0] st2;
    logic [7:0] st3;
    logic [7:0] cylinder;
    logic [7:0] head_addr;
    logic [7:0] sector;
    logic [7:0] size_code;
    logic [7:0] present_cyl;
  } fcr_res_t;

  // Drive-side outputs, all active low
  typedef struct packed {
    logic head_select_n;
    logic write_data_n;
    logic write_enable_n;
    logic motor_n;
    logic drive_select_n;
    logic write_current_n;
    logic direction_n;
    logic step_n;
  } fcr_drv_out_t;

  // Drive-side sense inputs, all active low
  typedef struct packed {
    logic media_change_in_n;
    logic read_stream_in_n;
    logic write_protect_in_n;
    logic track_zero_in_n;
    logic index_n;
  } fcr_drv_in_t;

  function automatic fcr_kind_t fcr_decode(input logic [7:0] op);
    logic [7:0] low;
    low = op & `FCR_OP_MASK;
    if (low == `FCR_OP_SCAN_EQ || low == `FCR_OP_SCAN_LE || low == `FCR_OP_SCAN_HE) begin
      return fcr_k_scan;
    end
    unique case (op)
      `FCR_OP_RECAL: return fcr_k_recal;
      `FCR_OP_SENSE_INT: return fcr_k_sense_int;
      `FCR_OP_SPECIFY: return fcr_k_specify;
      `FCR_OP_SENSE_DRV: return fcr_k_sense_drv;
      `FCR_OP_SEEK: return fcr_k_seek;
      default: return fcr_k_invalid;
    endcase
  endfunction

  function automatic logic [3:0] fcr_cmd_len(input fcr_kind_t k);
    unique case (k)
      fcr_k_scan: return `FCR_LEN_SCAN;
      fcr_k_recal, fcr_k_sense_drv: return `FCR_LEN_TWO;
      fcr_k_specify, fcr_k_seek: return `FCR_LEN_THREE;
      default: return `FCR_LEN_ONE;
    endcase
  endfunction

  function automatic logic [3:0] fcr_res_len(input fcr_kind_t k);
    unique case (k)
      fcr_k_scan: return `FCR_RES_SCAN;
      fcr_k_sense_int: return `FCR_LEN_TWO;
      fcr_k_sense_drv, fcr_k_invalid: return `FCR_LEN_ONE;
      default: return `FCR_RES_NONE;
    endcase
  endfunction

endpackage

// [core/fcr_byte_mem.sv]
// Purpose: small byte store for result bytes awaiting the host
// Assumes: one write and one read per cycle
// Notes: read data is registered, so a read costs one cycle
`timescale 1ns/1ps
`default_nettype none

module fcr_byte_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

`default_nettype wire

// [core/fcr_cmd_seq.sv]
// Purpose: command/result byte sequencer and external drive pin steering
// Assumes: an execution engine outside runs each command and reports back
// Notes: no result bytes for positioning, recalibrate or timing commands
//
// Behaviour
// - Each scan command returns seven result bytes, size code last.
// - Recalibrate, specify and seek end after command bytes; no results offered.
// - Unknown opcode answers one status-0 byte, then waits for a new command.
// - Drive signals reach printer pins only while the enable bit is one.
// - External mode drives eight drive outputs, reads five sense lines.
`timescale 1ns/1ps
`default_nettype none
`include "fcr_regs.svh"

module fcr_cmd_seq import fcr_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Host command and result bytes
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  input wire logic res_rd,
  output logic [7:0] res_data,
  output logic res_valid,
  output logic busy,
  // Execution engine
  output logic exec_start,
  output fcr_cmd_t exec_cmd,
  input wire logic exec_done,
  input wire fcr_res_t exec_result,
  // Controller and printer logic
  input wire logic ext_drive_en,
  input wire fcr_drv_out_t drv_out,
  output fcr_drv_in_t drv_in,
  input wire logic [2:0] prn_ctrl,
  input wire logic [7:0] prn_data,
  input wire logic prn_data_drive,
  output logic [4:0] prn_status,
  // Printer port pins
  input wire logic [4:0] pp_status_in,
  output logic [4:0] pp_status_out,
  output logic pp_status_oe,
  output logic [2:0] pp_ctrl_out,
  output logic pp_ctrl_oe,
  input wire logic [7:0] pp_data_in,
  output logic [7:0] pp_data_out,
  output logic pp_data_oe
);

  // ----------------------------------------------------------------
  // Command capture
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    st_idle, st_cmd, st_exec, st_load, st_fetch, st_show, st_wait
  } fcr_state_t;

  function automatic fcr_cmd_t fcr_capture(input fcr_cmd_t c, input logic [3:0] i,
                                           input logic [7:0] b);
    fcr_cmd_t r;
    r = c;
    unique case (i)
      `FCR_IDX_0: begin
        r = '0;
        r.opcode = b;
        r.multi_track_flag = b[`FCR_BIT_MT];
        r.density_select_flag = b[`FCR_BIT_MF];
        r.skip_deleted_flag = b[`FCR_BIT_SK];
      end
      `FCR_IDX_1: begin
        r.head_select = b[`FCR_BIT_HD];
        r.unit_select_high = b[`FCR_BIT_US1];
        r.unit_select_low = b[`FCR_BIT_US0];
        r.step_rate_time = b[7:`FCR_SRT_LSB];
        r.head_unload_time = b[`FCR_SRT_LSB-1:0];
      end
      `FCR_IDX_2: begin
        r.cylinder = b;
        r.head_load_time = b[7:`FCR_HLT_LSB];
        r.non_dma_select = b[`FCR_BIT_ND];
      end
      `FCR_IDX_3: r.head_addr = b;
      `FCR_IDX_4: r.sector = b;
      `FCR_IDX_5: r.size_code = b;
      `FCR_IDX_6: r.end_of_track = b;
      `FCR_IDX_7: r.gap_length = b;
      default: r.scan_test = b;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] fcr_result_byte(input fcr_kind_t k, input logic [3:0] i,
                                                 input fcr_res_t s);
    if (k == fcr_k_invalid) begin
      return `FCR_ST0_INVALID;
    end
    if (k == fcr_k_sense_drv) begin
      return s.st3;
    end
    if (k == fcr_k_sense_int) begin
      return (i == `FCR_IDX_0) ? s.st0 : s.present_cyl;
    end
    unique case (i)
      `FCR_IDX_0: return s.st0;
      `FCR_IDX_1: return s.st1;
      `FCR_IDX_2: return s.st2;
      `FCR_IDX_3: return s.cylinder;
      `FCR_IDX_4: return s.head_addr;
      `FCR_IDX_5: return s.sector;
      default: return s.size_code;
    endcase
  endfunction

  fcr_state_t state, next_state;
  fcr_kind_t kind, next_kind, cur_kind;
  fcr_cmd_t next_cmd;
  fcr_res_t res_hold, next_res_hold;
  logic [3:0] idx, next_idx;
  logic [2:0] rd_idx, next_rd_idx;
  logic next_start, next_res_valid, next_cmd_ready, next_busy;
  logic [7:0] next_res_data, mem_wdata, mem_rdata;
  logic mem_we, cmd_acc;

  assign cmd_acc = cmd_wr && cmd_ready;

  always_comb begin
    next_state = state;
    next_kind = kind;
    next_cmd = exec_cmd;
    next_res_hold = res_hold;
    next_idx = idx;
    next_rd_idx = rd_idx;
    next_start = 1'b0;
    next_res_valid = res_valid;
    next_res_data = res_data;
    mem_we = 1'b0;
    mem_wdata = 8'h00;
    cur_kind = (state == st_idle) ? fcr_decode(cmd_data) : kind;
    unique case (state)
      st_idle, st_cmd: begin
        if (cmd_acc) begin
          next_kind = cur_kind;
          next_cmd = fcr_capture(exec_cmd, idx, cmd_data);
          if (cur_kind == fcr_k_invalid) begin
            next_state = st_load;
            next_idx = `FCR_IDX_0;
          end else if (idx == fcr_cmd_len(cur_kind) - `FCR_LEN_ONE) begin
            next_start = 1'b1;
            next_idx = `FCR_IDX_0;
            next_state = (fcr_res_len(cur_kind) == `FCR_RES_NONE) ? st_idle : st_exec;
          end else begin
            next_state = st_cmd;
            next_idx = idx + `FCR_IDX_1;
          end
        end
      end
      st_exec: begin
        if (exec_done) begin
          next_res_hold = exec_result;
          next_state = st_load;
        end
      end
      st_load: begin
        // Results staged first so the host never waits mid-sequence on the engine
        mem_we = 1'b1;
        mem_wdata = fcr_result_byte(kind, idx, res_hold);
        if (idx == fcr_res_len(kind) - `FCR_LEN_ONE) begin
          next_state = st_fetch;
          next_idx = `FCR_IDX_0;
          next_rd_idx = '0;
        end else begin
          next_idx = idx + `FCR_IDX_1;
        end
      end
      st_fetch: next_state = st_show;
      st_show: begin
        next_res_data = mem_rdata;
        next_res_valid = 1'b1;
        next_state = st_wait;
      end
      st_wait: begin
        if (res_rd) begin
          next_res_valid = 1'b0;
          if ({1'b0, rd_idx} == fcr_res_len(kind) - `FCR_LEN_ONE) begin
            next_state = st_idle;
            next_rd_idx = '0;
          end else begin
            next_state = st_fetch;
            next_rd_idx = rd_idx + 3'h1;
          end
        end
      end
      default: next_state = st_idle;
    endcase
    next_cmd_ready = (next_state == st_idle) || (next_state == st_cmd);
    next_busy = (next_state != st_idle);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= st_idle;
      kind <= fcr_k_invalid;
      exec_cmd <= '0;
      res_hold <= '0;
      idx <= `FCR_IDX_0;
      rd_idx <= '0;
      exec_start <= 1'b0;
      res_valid <= 1'b0;
      res_data <= 8'h00;
      cmd_ready <= 1'b0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      exec_cmd <= next_cmd;
      res_hold <= next_res_hold;
      idx <= next_idx;
      rd_idx <= next_rd_idx;
      exec_start <= next_start;
      res_valid <= next_res_valid;
      res_data <= next_res_data;
      cmd_ready <= next_cmd_ready;
      busy <= next_busy;
    end
  end

  fcr_byte_mem #(.WIDTH(8), .DEPTH(8), .AW(3)) u_res_mem (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wr_en(mem_we),
    .wr_addr(idx[2:0]),
    .wr_data(mem_wdata),
    .rd_addr(rd_idx),
    .rd_data(mem_rdata)
  );

  // ----------------------------------------------------------------
  // Printer port steering
  // ----------------------------------------------------------------
  logic [4:0] next_status_out, next_prn_status;
  logic [2:0] next_ctrl_out;
  logic [7:0] next_data_out;
  logic next_status_oe, next_data_oe;
  fcr_drv_in_t next_drv_in;

  always_comb begin
    next_status_oe = ext_drive_en;
    next_status_out = {drv_out.head_select_n, drv_out.write_data_n, drv_out.write_enable_n,
                       drv_out.motor_n, drv_out.drive_select_n};
    next_ctrl_out = ext_drive_en ?
                    {drv_out.write_current_n, drv_out.direction_n, drv_out.step_n} :
                    prn_ctrl;
    // Data lines turn around to inputs so the drive can drive its sense lines
    next_data_oe = prn_data_drive && !ext_drive_en;
    next_data_out = prn_data;
    next_drv_in = ext_drive_en ? fcr_drv_in_t'(pp_data_in[4:0]) :
                  fcr_drv_in_t'(`FCR_SENSE_IDLE);
    next_prn_status = ext_drive_en ? `FCR_SENSE_IDLE : pp_status_in;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pp_status_oe <= 1'b0;
      pp_status_out <= `FCR_SENSE_IDLE;
      pp_ctrl_out <= `FCR_CTRL_IDLE;
      pp_ctrl_oe <= 1'b0;
      pp_data_oe <= 1'b0;
      pp_data_out <= 8'h00;
      drv_in <= fcr_drv_in_t'(`FCR_SENSE_IDLE);
      prn_status <= `FCR_SENSE_IDLE;
    end else begin
      pp_status_oe <= next_status_oe;
      pp_status_out <= next_status_out;
      pp_ctrl_out <= next_ctrl_out;
      pp_ctrl_oe <= 1'b1;
      pp_data_oe <= next_data_oe;
      pp_data_out <= next_data_out;
      drv_in <= next_drv_in;
      prn_status <= next_prn_status;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_scan_seven_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == st_load && kind == fcr_k_scan && idx == `FCR_IDX_0) |-> ##7 state == st_fetch)
    else $error("scan result staging not seven bytes");
  a_scan_size_last: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == st_wait && kind == fcr_k_scan && rd_idx == 3'h6) |-> res_data == res_hold.size_code)
    else $error("scan last result byte is not size code");
  a_no_result_cmds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (exec_start && (kind == fcr_k_recal || kind == fcr_k_specify || kind == fcr_k_seek))
      |-> (!res_valid && state != st_load) [*4])
    else $error("result offered for a command without results");
  a_invalid_answer: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cmd_acc && state == st_idle && fcr_decode(cmd_data) == fcr_k_invalid)
      |-> ##[1:6] (res_valid && res_data == `FCR_ST0_INVALID))
    else $error("invalid opcode not answered with status 0");
  a_status_pins_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 (pp_status_oe == $past(ext_drive_en) && (pp_data_oe -> !$past(ext_drive_en))))
    else $error("printer status pins steered against enable");
  a_ctrl_pins_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ext_drive_en |=> (pp_ctrl_out[0] == $past(drv_out.step_n)
                      && drv_in.index_n == $past(pp_data_in[0])))
    else $error("drive signals not mapped onto printer pins");
  a_start_after_last: assert property (@(posedge sys_clk) disable iff (!rst_n)
    exec_start |-> $past(cmd_acc))
    else $error("execution began without a final command byte");
  a_one_at_time: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (res_valid && res_rd) |=> !res_valid ##1 !res_valid)
    else $error("next result byte presented too early");

endmodule

`default_nettype wire

// [sim/fcr_engine_model.sv]
// Purpose: execution engine stand-in that answers each started command
// Assumes: result fields are res_base plus a fixed per-field offset
// Notes: result bus shows inverted data outside the done cycle
`timescale 1ns/1ps
`default_nettype none

module fcr_engine_model import fcr_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Engine handshake
  input wire logic exec_start,
  output logic exec_done,
  output fcr_res_t exec_result,
  // Scenario control
  input wire logic [7:0] res_base,
  input wire logic [4:0] delay
);
  logic armed;
  logic [4:0] cnt;
  fcr_res_t good;

  // ----------------------------------------------------------------
  // Answer after a chosen delay
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    exec_done <= 1'b0;
    if (!rst_n) begin
      armed <= 1'b0;
    end else if (exec_start) begin
      armed <= 1'b1;
      cnt <= delay;
    end else if (armed) begin
      if (cnt == 5'h00) begin
        armed <= 1'b0;
        exec_done <= 1'b1;
      end else begin
        cnt <= cnt - 5'h01;
      end
    end
  end

  // Stale data never looks valid to the sequencer
  always_comb begin
    good.st0 = res_base;
    good.st1 = res_base + 8'h01;
    good.st2 = res_base + 8'h02;
    good.cylinder = res_base + 8'h03;
    good.head_addr = res_base + 8'h04;
    good.sector = res_base + 8'h05;
    good.size_code = res_base + 8'h06;
    good.st3 = res_base + 8'h07;
    good.present_cyl = res_base + 8'h08;
    exec_result = exec_done ? good : ~good;
  end
endmodule
`default_nettype wire

// [sim/fcr_cmd_seq_tb.sv]
// Purpose: self-checking bench for the command/result sequencer
// Assumes: engine model answers with res_base-derived results
// Notes: pin steering checked in both modes with two patterns
`timescale 1ns/1ps
`default_nettype none
`include "fcr_regs.svh"

module fcr_cmd_seq_tb import fcr_pkg::*;;
  logic sys_clk, rst_n, cmd_wr, cmd_ready, res_rd, res_valid, busy, exec_start, exec_done;
  logic [7:0] cmd_data, res_data, res_base, prn_data, pp_data_in, pp_data_out;
  logic [4:0] eng_delay, prn_status, pp_status_in, pp_status_out;
  logic [2:0] prn_ctrl, pp_ctrl_out;
  logic ext_drive_en, prn_data_drive, pp_status_oe, pp_ctrl_oe, pp_data_oe;
  fcr_cmd_t exec_cmd, last_cmd;
  fcr_res_t exec_result;
  fcr_drv_out_t drv_out;
  fcr_drv_in_t drv_in;
  logic [7:0] q [9];
  int n_errors = 0;
  int total_checks = 0;
  int n_starts = 0;

  fcr_cmd_seq dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_wr(cmd_wr), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .res_rd(res_rd), .res_data(res_data), .res_valid(res_valid),
    .busy(busy), .exec_start(exec_start), .exec_cmd(exec_cmd), .exec_done(exec_done),
    .exec_result(exec_result), .ext_drive_en(ext_drive_en), .drv_out(drv_out),
    .drv_in(drv_in), .prn_ctrl(prn_ctrl), .prn_data(prn_data),
    .prn_data_drive(prn_data_drive), .prn_status(prn_status), .pp_status_in(pp_status_in),
    .pp_status_out(pp_status_out), .pp_status_oe(pp_status_oe), .pp_ctrl_out(pp_ctrl_out),
    .pp_ctrl_oe(pp_ctrl_oe), .pp_data_in(pp_data_in), .pp_data_out(pp_data_out),
    .pp_data_oe(pp_data_oe));

  fcr_engine_model eng_u (.sys_clk(sys_clk), .rst_n(rst_n), .exec_start(exec_start),
    .exec_done(exec_done), .exec_result(exec_result), .res_base(res_base), .delay(eng_delay));

  // ----------------------------------------------------------------
  // Clock, start monitor, watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (exec_start === 1'b1) begin
      n_starts <= n_starts + 1;
      last_cmd <= exec_cmd;
    end
  end

  // Whole run needs several hundred cycles
  initial begin
    #200000;
    n_errors++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Bytes go back to back; strobe held high across the whole command
  task automatic send(input int n);
    int k;
    cmd_wr = 1'b1;
    for (int i = 0; i < n; i++) begin
      cmd_data = q[i];
      k = 0;
      // Ready only moves on edges, so its value now is what the next edge samples
      while (cmd_ready !== 1'b1 && k < 50) begin
        k++;
        @(posedge sys_clk);
        #1;
      end
      if (k == 50) begin
        n_errors++;
        $display("[ERR] cmd_ready expected 1 seen %b", cmd_ready);
      end
      @(posedge sys_clk);
      #1;
    end
    cmd_wr = 1'b0;
  endtask

  task automatic read_res(input logic [7:0] e);
    int k;
    k = 0;
    while (res_valid !== 1'b1 && k < 100) begin
      k++;
      @(posedge sys_clk);
      #1;
    end
    chk1("res_valid", 1'b1, res_valid);
    chk1("busy", 1'b1, busy);
    chk1("cmd_ready", 1'b0, cmd_ready);
    chk8("res_data", e, res_data);
    res_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    res_rd = 1'b0;
  endtask

  task automatic idle_chk();
    repeat (30) @(posedge sys_clk);
    #1;
    chk1("res_valid", 1'b0, res_valid);
    chk1("cmd_ready", 1'b1, cmd_ready);
    chk1("busy", 1'b0, busy);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_scan();
    logic [7:0] ops [3];
    int st;
    ops = '{`FCR_OP_SCAN_EQ, `FCR_OP_SCAN_LE | 8'hE0, `FCR_OP_SCAN_HE};
    for (int s = 0; s < 3; s++) begin
      q = '{ops[s], 8'h05, 8'h22, 8'h01, 8'h03, 8'h02, 8'h12, 8'h1B, 8'(s)};
      res_base = 8'h40 + 8'(s * 16);
      eng_delay = (s == 2) ? 5'h14 : 5'h01;
      st = n_starts;
      send(9);
      for (int i = 0; i < 7; i++) begin
        read_res(res_base + 8'(i));
      end
      chk8("starts", 8'h01, 8'(n_starts - st));
      chk8("cyl", 8'h22, last_cmd.cylinder);
      chk8("scan_test", 8'(s), last_cmd.scan_test);
      chk1("head_select", 1'b1, last_cmd.head_select);
      chk1("multi_track", s == 1, last_cmd.multi_track_flag);
      idle_chk();
    end
  endtask

  // Recalibrate and seek sent as one back-to-back burst
  task automatic t_noresult();
    int st;
    st = n_starts;
    q = '{`FCR_OP_RECAL, 8'h02, `FCR_OP_SEEK, 8'h06, 8'h4C, 8'h00, 8'h00, 8'h00, 8'h00};
    send(5);
    idle_chk();
    chk8("starts", 8'h02, 8'(n_starts - st));
    chk8("seek_cyl", 8'h4C, last_cmd.cylinder);
    q = '{`FCR_OP_SPECIFY, 8'hA5, 8'h1F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    send(3);
    idle_chk();
    chk8("srt", 8'h0A, 8'(last_cmd.step_rate_time));
    chk8("hut", 8'h05, 8'(last_cmd.head_unload_time));
    chk8("hlt", 8'h0F, 8'(last_cmd.head_load_time));
    chk1("nd", 1'b1, last_cmd.non_dma_select);
  endtask

  task automatic t_sense();
    res_base = 8'h90;
    eng_delay = 5'h03;
    q[0] = `FCR_OP_SENSE_INT;
    send(1);
    read_res(8'h90);
    read_res(8'h98);
    idle_chk();
    q = '{`FCR_OP_SENSE_DRV, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    send(2);
    read_res(8'h97);
    idle_chk();
  endtask

  task automatic t_invalid();
    int st;
    for (int i = 0; i < 2; i++) begin
      st = n_starts;
      q[0] = i ? 8'hFF : 8'h00;
      send(1);
      read_res(`FCR_ST0_INVALID);
      idle_chk();
      chk8("starts", 8'h00, 8'(n_starts - st));
    end
  endtask

  task automatic t_pins();
    logic md;
    for (int m = 0; m < 4; m++) begin
      md = m[0];
      ext_drive_en = md;
      drv_out = m[1] ? 8'h59 : 8'hA6;
      prn_ctrl = m[1] ? 3'h2 : 3'h5;
      prn_data = m[1] ? 8'hC3 : 8'h3C;
      prn_data_drive = m[1];
      pp_status_in = m[1] ? 5'h15 : 5'h0A;
      pp_data_in = m[1] ? 8'h16 : 8'hE9;
      repeat (3) @(posedge sys_clk);
      #1;
      chk1("status_oe", md, pp_status_oe);
      chk1("ctrl_oe", 1'b1, pp_ctrl_oe);
      chk1("data_oe", md ? 1'b0 : prn_data_drive, pp_data_oe);
      chk8("ctrl_out", 8'(md ? drv_out[2:0] : prn_ctrl), 8'(pp_ctrl_out));
      chk8("drv_in", 8'(md ? pp_data_in[4:0] : 5'h1F), 8'(drv_in));
      chk8("prn_status", 8'(md ? 5'h1F : pp_status_in), 8'(prn_status));
      if (md) begin
        chk8("status_out", 8'(drv_out[7:3]), 8'(pp_status_out));
      end else begin
        chk8("data_out", prn_data, pp_data_out);
      end
    end
    ext_drive_en = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    cmd_wr = 1'b0;
    cmd_data = 8'h00;
    res_rd = 1'b0;
    res_base = 8'h00;
    eng_delay = 5'h01;
    ext_drive_en = 1'b0;
    drv_out = 8'hFF;
    prn_ctrl = 3'h0;
    prn_data = 8'h00;
    prn_data_drive = 1'b0;
    pp_status_in = 5'h1F;
    pp_data_in = 8'hFF;
    repeat (10) @(posedge sys_clk);
    #1;
    chk1("cmd_ready", 1'b0, cmd_ready);
    chk1("res_valid", 1'b0, res_valid);
    chk1("status_oe", 1'b0, pp_status_oe);
    chk8("drv_in", 8'h1F, 8'(drv_in));
    rst_n = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk1("cmd_ready", 1'b1, cmd_ready);
    t_scan();
    t_noresult();
    t_sense();
    t_invalid();
    t_pins();
    test_done();
  end
endmodule
`default_nettype wire
